// ==== rtl/scan_pkg.sv ====
// Purpose: shared constants and types for the dual-die scan decoder
// Assumes: two dies of 4-bit instruction each, chained into one 8-bit path
// Notes:   codes below are the combined 8-bit instruction values
package scan_pkg;

   // ----------------------------------------------------------------
   // widths and fixed patterns
   // ----------------------------------------------------------------
   localparam int unsigned DIE_IR_W  = 4;
   localparam int unsigned NUM_DIES  = 2;
   localparam int unsigned IR_W      = DIE_IR_W * NUM_DIES;
   localparam int unsigned ID_W      = 64;
   localparam int unsigned SYNC_W    = 2;
   localparam int unsigned TLR_TMS_N = 5;
   localparam int unsigned TMS_CNT_W = 3;
   // each die captures 0001, so the two low bits of every nibble read 01
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h11;

   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
   localparam logic [IR_W-1:0] INS_SAMPLE = 8'h11;
   localparam logic [IR_W-1:0] INS_IDCODE = 8'h22;
   localparam logic [IR_W-1:0] INS_HIGHZ  = 8'h33;
   localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET    = 4'h0,
      ST_IDLE     = 4'h1,
      ST_SEL_DR   = 4'h3,
      ST_CAP_DR   = 4'h2,
      ST_SHIFT_DR = 4'h6,
      ST_EXIT1_DR = 4'h7,
      ST_PAUSE_DR = 4'h5,
      ST_EXIT2_DR = 4'h4,
      ST_UPD_DR   = 4'hC,
      ST_SEL_IR   = 4'hD,
      ST_CAP_IR   = 4'hF,
      ST_SHIFT_IR = 4'hE,
      ST_EXIT1_IR = 4'hA,
      ST_PAUSE_IR = 4'hB,
      ST_EXIT2_IR = 4'h9,
      ST_UPD_IR   = 4'h8
   } tap_state_t;

   typedef enum logic [1:0] {
      DSEL_BYP = 2'h0,
      DSEL_ID  = 2'h1,
      DSEL_BSR = 2'h2
   } dsel_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } scan_pins_t;

endpackage

// ==== rtl/scan_decoder.sv ====
// Purpose: boundary-scan tap, 8-bit instruction path and data register mux
// Assumes: tck and the other scan pins are slow against clk (160 ns tck)
// Notes:   every tck edge is found by oversampling; tdo moves on tck fall
`timescale 1ns/1ps

// Function
// - instruction bits shift in only while the tap sits in Shift-IR
// - instruction path is 8 bits: two chained 4-bit die registers
// - current instruction picks the data register between tdi and tdo
// - unselected data registers stay untouched and leave pins alone
// - code 00 selects boundary register in external test mode
// - external test drives boundary values on pins, captures pin inputs
// - code 22 keeps function, puts 64-bit identity register in path
// - reading identity register never disturbs normal operation
// - identity is the instruction after reset, no load needed
// - code 11 keeps function, boundary register samples live pins
// - code 33 floats every pad output and selects the bypass stage
// - code FF keeps function and passes data through bypass stage
// - new instruction takes effect only on latch in Update-IR
// - Capture-IR loads a fixed pattern whose low two bits are 01
// - selected bypass stage clears to zero on Capture-DR rising edge
// - five tck rises with tms high reach Test-Logic-Reset
module scan_decoder #(
   parameter int unsigned       NUM_IN   = 4,
   parameter int unsigned       NUM_OUT  = 4,
   // arbitrary neutral identity, one word per die, lsb set as required
   parameter logic [63:0]       ID_VALUE = 64'h0ABC_D001_0ABC_D001
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire scan_pkg::scan_pins_t      pins,
   input  wire logic [NUM_IN-1:0]         pad_in,
   input  wire logic [NUM_OUT-1:0]        core_out,
   input  wire logic [NUM_OUT-1:0]        core_oe,
   output      logic                      tdo,
   output      logic                      tdo_oe,
   output      logic [NUM_OUT-1:0]        pad_out,
   output      logic [NUM_OUT-1:0]        pad_oe,
   output      logic [scan_pkg::IR_W-1:0] instr,
   output      logic                      tap_reset
);

   localparam int unsigned BSR_W = NUM_IN + NUM_OUT;
   localparam int unsigned IR_W  = scan_pkg::IR_W;
   localparam int unsigned ID_W  = scan_pkg::ID_W;
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int unsigned PW = 4 + NUM_IN;
   logic [PW-1:0] meta_reg;
   logic [PW-1:0] sync_reg;
   logic          tck_d_reg;
   wire  [PW-1:0] raw_in = {pad_in, pins.trst_n, pins.tdi, pins.tms,
                             pins.tck};

   genvar g;
   generate
      for (g = 0; g < PW; g++) begin : g_sync
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= raw_in[g];
               sync_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate

   wire              tck_s   = sync_reg[0];
   wire              tms_s   = sync_reg[1];
   wire              tdi_s   = sync_reg[2];
   wire              trst_s  = sync_reg[3];
   wire [NUM_IN-1:0] pin_s   = sync_reg[PW-1:4];
   wire              tck_rise = tck_s & ~tck_d_reg;
   wire              tck_fall = ~tck_s & tck_d_reg;

   // ----------------------------------------------------------------
   // tap state machine
   // ----------------------------------------------------------------
   function automatic scan_pkg::tap_state_t tap_next(
      input scan_pkg::tap_state_t s,
      input logic                 m
   );
      case (s)
         scan_pkg::ST_RESET:    tap_next = m ? scan_pkg::ST_RESET
                                             : scan_pkg::ST_IDLE;
         scan_pkg::ST_IDLE:     tap_next = m ? scan_pkg::ST_SEL_DR
                                             : scan_pkg::ST_IDLE;
         scan_pkg::ST_SEL_DR:   tap_next = m ? scan_pkg::ST_SEL_IR
                                             : scan_pkg::ST_CAP_DR;
         scan_pkg::ST_CAP_DR,
         scan_pkg::ST_SHIFT_DR: tap_next = m ? scan_pkg::ST_EXIT1_DR
                                             : scan_pkg::ST_SHIFT_DR;
         scan_pkg::ST_EXIT1_DR: tap_next = m ? scan_pkg::ST_UPD_DR
                                             : scan_pkg::ST_PAUSE_DR;
         scan_pkg::ST_PAUSE_DR: tap_next = m ? scan_pkg::ST_EXIT2_DR
                                             : scan_pkg::ST_PAUSE_DR;
         scan_pkg::ST_EXIT2_DR: tap_next = m ? scan_pkg::ST_UPD_DR
                                             : scan_pkg::ST_SHIFT_DR;
         scan_pkg::ST_SEL_IR:   tap_next = m ? scan_pkg::ST_RESET
                                             : scan_pkg::ST_CAP_IR;
         scan_pkg::ST_CAP_IR,
         scan_pkg::ST_SHIFT_IR: tap_next = m ? scan_pkg::ST_EXIT1_IR
                                             : scan_pkg::ST_SHIFT_IR;
         scan_pkg::ST_EXIT1_IR: tap_next = m ? scan_pkg::ST_UPD_IR
                                             : scan_pkg::ST_PAUSE_IR;
         scan_pkg::ST_PAUSE_IR: tap_next = m ? scan_pkg::ST_EXIT2_IR
                                             : scan_pkg::ST_PAUSE_IR;
         scan_pkg::ST_EXIT2_IR: tap_next = m ? scan_pkg::ST_UPD_IR
                                             : scan_pkg::ST_SHIFT_IR;
         scan_pkg::ST_UPD_DR,
         scan_pkg::ST_UPD_IR:   tap_next = m ? scan_pkg::ST_SEL_DR
                                             : scan_pkg::ST_IDLE;
         default:               tap_next = scan_pkg::ST_RESET;
      endcase
   endfunction

   scan_pkg::tap_state_t state_reg;
   scan_pkg::tap_state_t state_next;
   assign state_next = tap_next(state_reg, tms_s);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= scan_pkg::ST_RESET;
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= tck_s;
         if (!trst_s)
            state_reg <= scan_pkg::ST_RESET;
         else if (tck_rise)
            state_reg <= state_next;
      end
   end

   wire in_reset  = (state_reg == scan_pkg::ST_RESET);
   wire cap_ir    = (state_reg == scan_pkg::ST_CAP_IR);
   wire shift_ir  = (state_reg == scan_pkg::ST_SHIFT_IR);
   wire upd_ir    = (state_reg == scan_pkg::ST_UPD_IR);
   wire cap_dr    = (state_reg == scan_pkg::ST_CAP_DR);
   wire shift_dr  = (state_reg == scan_pkg::ST_SHIFT_DR);
   wire upd_dr    = (state_reg == scan_pkg::ST_UPD_DR);

   // ----------------------------------------------------------------
   // instruction path and decode
   // ----------------------------------------------------------------
   logic [IR_W-1:0] ir_sh_reg;
   logic [IR_W-1:0] instr_reg;
   // tdi enters at the top; 8 shifts fill both die nibbles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ir_sh_reg <= scan_pkg::IR_CAPTURE;
      else if (tck_rise && cap_ir)
         ir_sh_reg <= scan_pkg::IR_CAPTURE;
      else if (tck_rise && shift_ir)
         ir_sh_reg <= {tdi_s, ir_sh_reg[IR_W-1:1]};
   end

   // latch on the falling edge so the path never changes mid-shift
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         instr_reg <= scan_pkg::INS_IDCODE;
      else if (in_reset)
         instr_reg <= scan_pkg::INS_IDCODE;
      else if (tck_fall && upd_ir)
         instr_reg <= ir_sh_reg;
   end

   wire is_extest = (instr_reg == scan_pkg::INS_EXTEST);
   wire is_sample = (instr_reg == scan_pkg::INS_SAMPLE);
   wire is_idcode = (instr_reg == scan_pkg::INS_IDCODE);
   wire is_highz  = (instr_reg == scan_pkg::INS_HIGHZ);

   // everything not listed, 0xFF included, falls to bypass
   scan_pkg::dsel_t dsel;
   assign dsel = (is_extest | is_sample) ? scan_pkg::DSEL_BSR :
                 is_idcode               ? scan_pkg::DSEL_ID  :
                                           scan_pkg::DSEL_BYP;
   wire sel_byp = (dsel == scan_pkg::DSEL_BYP);
   wire sel_id  = (dsel == scan_pkg::DSEL_ID);
   wire sel_bsr = (dsel == scan_pkg::DSEL_BSR);

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   logic             byp_reg;
   logic [ID_W-1:0]  id_sh_reg;
   logic [BSR_W-1:0] bsr_sh_reg;
   logic [BSR_W-1:0] bsr_upd_reg;

   // only the selected register moves; the others hold their contents
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byp_reg    <= 1'b0;
         id_sh_reg  <= '0;
         bsr_sh_reg <= '0;
      end else if (tck_rise) begin
         if (cap_dr && sel_byp)
            byp_reg <= 1'b0;
         else if (shift_dr && sel_byp)
            byp_reg <= tdi_s;
         if (cap_dr && sel_id)
            id_sh_reg <= ID_VALUE;
         else if (shift_dr && sel_id)
            id_sh_reg <= {tdi_s, id_sh_reg[ID_W-1:1]};
         if (cap_dr && sel_bsr)
            bsr_sh_reg <= {pin_s, core_out};
         else if (shift_dr && sel_bsr)
            bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_W-1:1]};
      end
   end

   // update stage: holds preloaded values until the next Update-DR
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         bsr_upd_reg <= '0;
      else if (tck_fall && upd_dr && sel_bsr)
         bsr_upd_reg <= bsr_sh_reg;
   end

   // ----------------------------------------------------------------
   // serial output, retimed to the falling tck edge
   // ----------------------------------------------------------------
   wire dr_lsb = sel_bsr ? bsr_sh_reg[0] :
                 sel_id  ? id_sh_reg[0]  : byp_reg;
   wire tdo_next = shift_ir ? ir_sh_reg[0] : dr_lsb;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo    <= tdo_next;
         tdo_oe <= shift_ir | shift_dr;
      end
   end

   // ----------------------------------------------------------------
   // pad control
   // ----------------------------------------------------------------
   wire [NUM_OUT-1:0] pad_out_next = is_extest ? bsr_upd_reg[NUM_OUT-1:0]
                                               : core_out;
   wire [NUM_OUT-1:0] pad_oe_next  = is_highz  ? '0 :
                                     is_extest ? '1 : core_oe;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out   <= '0;
         pad_oe    <= '0;
         instr     <= scan_pkg::INS_IDCODE;
         tap_reset <= 1'b1;
      end else begin
         pad_out   <= pad_out_next;
         pad_oe    <= pad_oe_next;
         instr     <= instr_reg;
         tap_reset <= in_reset;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int unsigned   CW      = scan_pkg::TMS_CNT_W;
   localparam logic [CW-1:0] TLR_CNT = CW'(scan_pkg::TLR_TMS_N);
   logic [CW-1:0] tms_hi_cnt;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         tms_hi_cnt <= '0;
      else if (tck_rise)
         tms_hi_cnt <= !tms_s ? '0 :
                       (tms_hi_cnt == TLR_CNT) ? TLR_CNT : tms_hi_cnt + CW'(1);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_IR_SHIFT_ONLY: assert property (
      $changed(ir_sh_reg) |-> $past(tck_rise && (shift_ir || cap_ir)))
      else $error("instruction path moved outside capture or shift");
   AST_IR_EIGHT: assert property (
      tck_rise && shift_ir |=> ir_sh_reg[IR_W-1] == $past(tdi_s)
         && ir_sh_reg[IR_W-2:0] == $past(ir_sh_reg[IR_W-1:1]))
      else $error("instruction shift not 8 bits wide");
   AST_TDO_BYPASS: assert property (
      tck_fall && shift_dr && sel_byp |=> tdo == $past(byp_reg) && tdo_oe)
      else $error("tdo does not follow bypass stage");
   AST_UNSEL_STILL: assert property (
      tck_rise && !sel_id |=> $stable(id_sh_reg))
      else $error("unselected identity register moved");
   AST_EXTEST_PINS: assert property (
      is_extest ##1 is_extest |-> pad_out == $past(bsr_upd_reg[NUM_OUT-1:0])
         && pad_oe == '1)
      else $error("external test not driving boundary values");
   AST_BSR_CAPTURE: assert property (
      tck_rise && cap_dr && sel_bsr |=> bsr_sh_reg == $past({pin_s,core_out}))
      else $error("boundary capture wrong");
   AST_ID_CAPTURE: assert property (
      tck_rise && cap_dr && sel_id |=> id_sh_reg == ID_VALUE)
      else $error("identity not captured");
   AST_ID_FUNCTIONAL: assert property (
      is_idcode |=> pad_out == $past(core_out) && pad_oe == $past(core_oe))
      else $error("identity read disturbed pins");
   AST_RESET_IDCODE: assert property (
      in_reset |=> instr_reg == scan_pkg::INS_IDCODE ##1
         instr == scan_pkg::INS_IDCODE)
      else $error("reset state did not select identity");
   AST_SAMPLE_FUNC: assert property (
      is_sample |-> sel_bsr ##1 pad_out == $past(core_out))
      else $error("sample disturbed pins");
   AST_HIGHZ_OFF: assert property (
      is_highz |=> pad_oe == '0)
      else $error("high impedance left an output on");
   AST_BYPASS_FUNC: assert property (
      sel_byp && !is_highz |=> pad_oe == $past(core_oe)
         && pad_out == $past(core_out))
      else $error("bypass or unlisted code disturbed pins");
   AST_UNLISTED_BYPASS: assert property (
      !(is_extest || is_sample || is_idcode) |-> sel_byp)
      else $error("unlisted code not decoded as bypass");
   AST_IR_LATCH: assert property (
      $changed(instr_reg) |-> $past(in_reset || (tck_fall && upd_ir)))
      else $error("instruction changed outside update");
   AST_IR_CAPTURE: assert property (
      tck_rise && cap_ir |=> ir_sh_reg[1:0] == 2'h1)
      else $error("capture pattern low bits not 01");
   AST_BYP_CLEAR: assert property (
      tck_rise && cap_dr && sel_byp |=> !byp_reg)
      else $error("bypass not cleared in capture");
   AST_FIVE_TMS: assert property (
      tms_hi_cnt == TLR_CNT |-> in_reset)
      else $error("five tms highs did not reset tap");
   COV_IR_LOAD:  cover property (tck_fall && upd_ir);
   COV_EXTEST:   cover property (is_extest && tck_fall && upd_dr);
   COV_ID_SHIFT: cover property (sel_id && tck_rise && shift_dr);
   COV_HIGHZ:    cover property (is_highz && shift_dr);

endmodule

// ==== bench/scan_ctl_model.sv ====
// Purpose: behavioural boundary-scan controller on the far side of the pins
// Assumes: tck period 160 ns, tck edges land on falling clk edges
// Notes:   tck stands low between frames; released tdi shows its inverse
`timescale 1ns/1ps
module scan_ctl_model (
   output scan_pkg::scan_pins_t pins,
   input  wire logic            tdo
);
   logic tck_q;
   logic tms_q;
   logic tdi_q;
   logic trst_n_q;

   assign pins = '{tck: tck_q, tms: tms_q, tdi: tdi_q, trst_n: trst_n_q};

   initial begin
      tck_q    = 1'b0;
      tms_q    = 1'b1;
      tdi_q    = 1'b0;
      trst_n_q = 1'b1;
   end

   // ------------------------------------------------------------------
   // tck cycles and tap walks
   // ------------------------------------------------------------------
   // tdo is taken at the rise, where the device keeps it settled
   task automatic cyc(input logic m, input logic d, output logic q);
      tms_q = m;
      tdi_q = d;
      #80;
      tck_q = 1'b1;
      q     = tdo;
      #80;
      tck_q = 1'b0;
   endtask

   // tms sequence, first step in bit 0
   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         cyc(seq[i], tdi_q, q);
      end
   endtask

   task automatic reset_tap();
      walk(8'h1F, 5);
   endtask

   task automatic to_idle();
      walk(8'h00, 1);
   endtask

   // last bit leaves with tms high; tdi then no longer holds its value
   task automatic shift(input int n, input logic [63:0] din,
                        output logic [63:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         cyc(i == n - 1, din[i], dout[i]);
      end
      tdi_q = ~tdi_q;
   endtask

   // each die gets its own copy of the code, eight bits in all
   task automatic ir_scan(input logic [3:0] die, input logic hold,
                          output logic [7:0] cap);
      logic [63:0] d;
      walk(8'h03, 4);
      shift(8, {56'h0, die, die}, d);
      cap = d[7:0];
      if (hold) begin
         walk(8'h00, 1);
      end else begin
         walk(8'h01, 2);
      end
   endtask

   task automatic ir_finish();
      walk(8'h03, 3);
   endtask

   task automatic dr_scan(input int n, input logic [63:0] din,
                          output logic [63:0] dout);
      walk(8'h01, 3);
      shift(n, din, dout);
      walk(8'h01, 2);
   endtask

   task automatic trst_pulse();
      trst_n_q = 1'b0;
      #100;
      trst_n_q = 1'b1;
      #100;
   endtask
endmodule

// ==== bench/test_dual_die_jtag_instruction_decoder.sv ====
// Purpose: self-checking bench for the dual-die scan instruction decoder
// Assumes: four inputs and four outputs on the boundary path
// Notes:   tck is driven by the controller model, pads by this bench
`timescale 1ns/1ps
module test_dual_die_jtag_instruction_decoder;
   // arbitrary identity value
   localparam logic [63:0] ID_EXP = 64'h0123_4567_89AB_CDEF;

   logic                 clk;
   logic                 rst_n;
   scan_pkg::scan_pins_t pins;
   logic [3:0]           pad_in;
   logic [3:0]           core_out;
   logic [3:0]           core_oe;
   logic                 tdo;
   logic                 tdo_oe;
   logic [3:0]           pad_out;
   logic [3:0]           pad_oe;
   logic [7:0]           instr;
   logic                 tap_reset;
   logic [7:0]           cap;
   logic [63:0]          dout;
   int                   fails;
   int                   checked;

   scan_decoder #(.NUM_IN(4), .NUM_OUT(4), .ID_VALUE(ID_EXP)) dut_u (
      .clk(clk), .rst_n(rst_n), .pins(pins), .pad_in(pad_in),
      .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe),
      .pad_out(pad_out), .pad_oe(pad_oe), .instr(instr),
      .tap_reset(tap_reset));

   scan_ctl_model ctl_u (.pins(pins), .tdo(tdo));

   always #5 clk = ~clk;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (8) @(negedge clk);
   endtask

   task automatic set_pads(input logic [3:0] i, input logic [3:0] o,
                           input logic [3:0] e);
      @(negedge clk);
      pad_in   = i;
      core_out = o;
      core_oe  = e;
      settle();
   endtask

   task automatic results();
      if (fails == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_power_up();
      chk(instr, scan_pkg::INS_IDCODE);
      ctl_u.reset_tap();
      settle();
      chk(tap_reset, 1'b1);
      ctl_u.to_idle();
      settle();
      chk(tap_reset, 1'b0);
      set_pads(4'h5, 4'h9, 4'h6);
      ctl_u.dr_scan(64, 64'h0, dout);
      settle();
      chk(dout, ID_EXP);
      chk({pad_out, pad_oe}, {core_out, core_oe});
   endtask

   task automatic t_bypass();
      ctl_u.ir_scan(4'hF, 1'b0, cap);
      settle();
      chk(cap, scan_pkg::IR_CAPTURE);
      chk(instr, scan_pkg::INS_BYPASS);
      ctl_u.dr_scan(8, 64'hA5, dout);
      settle();
      chk(dout[7:0], 8'h4A);
      chk(instr, scan_pkg::INS_BYPASS);
      chk(tdo_oe, 1'b0);
   endtask

   // held in the pause state, the shifted code must not take effect
   task automatic t_hold_then_sample();
      ctl_u.ir_scan(4'h1, 1'b1, cap);
      settle();
      chk(instr, scan_pkg::INS_BYPASS);
      ctl_u.ir_finish();
      settle();
      chk(instr, scan_pkg::INS_SAMPLE);
      set_pads(4'h9, 4'h6, 4'h5);
      ctl_u.dr_scan(8, 64'h3C, dout);
      settle();
      chk(dout[7:0], 8'h96);
      chk({pad_out, pad_oe}, 8'h65);
   endtask

   task automatic t_extest();
      ctl_u.ir_scan(4'h0, 1'b0, cap);
      settle();
      chk(instr, scan_pkg::INS_EXTEST);
      chk({pad_out, pad_oe}, 8'hCF);
      set_pads(4'h3, 4'hA, 4'h0);
      chk(pad_out, 4'hC);
      ctl_u.dr_scan(8, 64'h05, dout);
      settle();
      chk(dout[7:0], 8'h3A);
      chk({pad_out, pad_oe}, 8'h5F);
   endtask

   task automatic t_highz();
      set_pads(4'h3, 4'hA, 4'hF);
      ctl_u.ir_scan(4'h3, 1'b0, cap);
      settle();
      chk(instr, scan_pkg::INS_HIGHZ);
      chk(pad_oe, 4'h0);
      ctl_u.dr_scan(4, 64'h7, dout);
      settle();
      chk(dout[3:0], 4'hE);
      chk(pad_oe, 4'h0);
   endtask

   task automatic t_unlisted();
      for (int i = 4; i < 16; i += 5) begin
         ctl_u.ir_scan(i[3:0], 1'b0, cap);
         settle();
         chk(instr, {i[3:0], i[3:0]});
         chk({pad_out, pad_oe}, {core_out, core_oe});
         ctl_u.dr_scan(4, 64'h9, dout);
         settle();
         chk(dout[3:0], 4'h2);
      end
   endtask

   // both reset paths start from a live state with a non-identity code
   task automatic t_trst();
      ctl_u.reset_tap();
      settle();
      chk(tap_reset, 1'b1);
      chk(instr, scan_pkg::INS_IDCODE);
      ctl_u.to_idle();
      ctl_u.ir_scan(4'hF, 1'b0, cap);
      settle();
      ctl_u.trst_pulse();
      settle();
      chk(tap_reset, 1'b1);
      chk(instr, scan_pkg::INS_IDCODE);
      ctl_u.to_idle();
      ctl_u.dr_scan(64, 64'h0, dout);
      settle();
      chk(dout, ID_EXP);
   endtask

   initial begin
      clk      = 1'b0;
      rst_n    = 1'b0;
      pad_in   = 4'h0;
      core_out = 4'h0;
      core_oe  = 4'h0;
      fails    = 0;
      checked  = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      settle();
      t_power_up();
      t_bypass();
      t_hold_then_sample();
      t_extest();
      t_highz();
      t_unlisted();
      t_trst();
      results();
   end

   // the whole run needs about 57 us
   initial begin
      #400_000;
      $display("unexpected at %0t: run did not finish", $time);
      fails++;
      results();
   end
endmodule
